// ==== pixel_tone_pkg.sv ====
package pixel_tone_pkg;

  localparam int PIX_W          = 12;
  localparam int PIX_MAX        = 4095;
  localparam int CH_N           = 3;
  localparam int LUT_PTS        = 257;
  localparam int LUT_IDX_W      = 8;
  localparam int LUT_STEP       = 16;
  localparam int GAMMA_N        = 9;
  localparam int GAMMA_KNOTS    = 16;
  localparam int GAM_SEG_W      = 4;
  localparam int INTERP_ONE     = 256;
  localparam int COEF_W         = 14;
  localparam int COEF_N         = 9;
  localparam int FRAC_W         = 10;
  localparam int HUE_SIXTH      = 120;
  localparam int HUE_FULL       = 720;
  localparam int HUE_8BIT_SHIFT = 2;
  localparam int HUE_8BIT_MAX   = 180;
  localparam int DEPTH_STEP     = 2;
  localparam int SHARP_DIV      = 8;
  localparam int FIFO_DEPTH     = 16;

  localparam logic [7:0] REG_TONE     = 8'h00;
  localparam logic [7:0] REG_CHAN     = 8'h04;
  localparam logic [7:0] REG_INDEX    = 8'h08;
  localparam logic [7:0] REG_VALUE    = 8'h0C;
  localparam logic [7:0] REG_CSPACE   = 8'h10;
  localparam logic [7:0] REG_COEF_SEL = 8'h14;
  localparam logic [7:0] REG_COEF_VAL = 8'h18;
  localparam logic [7:0] REG_SHARP    = 8'h1C;
  localparam logic [7:0] REG_DEPTH    = 8'h20;
  localparam logic [7:0] REG_STATUS   = 8'h24;

  localparam int F_GAMMA_LSB = 4;
  localparam int F_RGBV_LSB  = 4;
  localparam int F_LEVEL_LSB = 4;

  localparam logic [3:0]        GAMMA_RST  = 4'h8;
  localparam logic [3:0]        COEF_LAST  = 4'h8;
  localparam logic [8:0]        INDEX_LAST = 9'h100;
  localparam logic signed [13:0] COEF_MAX  = 14'sh0800;
  localparam logic signed [13:0] COEF_MIN  = 14'sh3800;

  localparam real GAMMA_EXP [GAMMA_N] = '{0.45, 0.5, 0.55, 0.6, 0.65, 0.75, 0.8, 0.9, 1.0};

  typedef enum logic [1:0] {TONE_OFF = 2'h0, TONE_GAMMA = 2'h1, TONE_LUT = 2'h2} tone_e;
  typedef enum logic [1:0] {CS_RGB = 2'h0, CS_HSI = 2'h1, CS_XYZ = 2'h2} cspace_e;
  typedef enum logic [1:0] {RGBV_OFF = 2'h0, RGBV_STD = 2'h1, RGBV_WIDE = 2'h2,
                            RGBV_CUSTOM = 2'h3} rgbv_e;
  typedef enum logic [1:0] {DEPTH_8 = 2'h0, DEPTH_10 = 2'h1, DEPTH_12 = 2'h2} depth_e;

  // Coefficient k sits at row k/3, column k%3, signed with 10 fraction bits
  typedef logic [COEF_N-1:0][COEF_W-1:0] mat_t;
  localparam mat_t MAT_STD  = {14'h0400, 14'h0000, 14'h0000, 14'h0000, 14'h0400,
                               14'h0000, 14'h0000, 14'h0000, 14'h0400};
  localparam mat_t MAT_WIDE = {14'h03D6, 14'h002A, 14'h0000, 14'h0000, 14'h0400,
                               14'h0000, 14'h0000, 14'h0124, 14'h02DC};
  localparam mat_t MAT_XYZ  = {14'h03CD, 14'h007A, 14'h0014, 14'h004A, 14'h02DC,
                               14'h00DA, 14'h00B9, 14'h016E, 14'h01A6};

endpackage

// ==== pixel_tone_color_pipeline.sv ====
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module pixel_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input  logic             clk,
  input  logic             rst,
  input  logic             in_valid,
  output logic             in_ready,
  input  logic [WIDTH-1:0] in_data,
  output logic             out_valid,
  input  logic             out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_s;

  fifo_s            q;
  fifo_s            d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[q.rp];
  assign level     = q.cnt;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage needs no reset; nothing reads it while empty
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end

  chk_fifo_bound: assert property (@(posedge clk) disable iff (rst)
    q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule // pixel_fifo

module pixel_tone_color_pipeline
  import pixel_tone_pkg::*;
#(
  parameter bit COLOR_MODEL = 1'b1
) (
  input  logic              clk,
  input  logic              rst,
  input  logic [7:0]        reg_addr,
  input  logic [31:0]       reg_wdata,
  input  logic              reg_wr,
  input  logic              reg_rd,
  output logic [31:0]       reg_rdata,
  input  logic              pix_valid,
  output logic              pix_ready,
  input  logic [PIX_W-1:0]  pix_red,
  input  logic [PIX_W-1:0]  pix_green,
  input  logic [PIX_W-1:0]  pix_blue,
  output logic              out_valid,
  input  logic              out_ready,
  output logic [PIX_W-1:0]  out_red,
  output logic [PIX_W-1:0]  out_green,
  output logic [PIX_W-1:0]  out_blue
);
  typedef logic [CH_N-1:0][PIX_W-1:0] pix_t;

  typedef struct packed {
    tone_e       tone;
    logic [3:0]  gamma;
    logic [1:0]  chan;
    logic [8:0]  index;
    cspace_e     cs;
    rgbv_e       rgbv;
    logic [3:0]  coef_sel;
    mat_t        coef;
    logic        sharp_en;
    logic [1:0]  sharp_lvl;
    depth_e      depth;
    logic [31:0] rdata;
    logic        s1_v;
    pix_t        s1;
    pix_t        h1;
    pix_t        h2;
    logic        s2_v;
    pix_t        s2;
  } st_s;

  localparam st_s ST_RST = '{tone: TONE_OFF, gamma: GAMMA_RST, cs: CS_RGB,
                             rgbv: RGBV_OFF, coef: MAT_STD, depth: DEPTH_12,
                             default: '0};

  st_s              q;
  st_s              d;
  logic [PIX_W-1:0] lut_q   [CH_N][LUT_PTS];
  logic [PIX_W-1:0] gam_rom [GAMMA_N][GAMMA_KNOTS+1];
  pix_t             pin;
  pix_t             tone;
  pix_t             sh;
  pix_t             cv;
  pix_t             hsi;
  pix_t             res;
  mat_t             mat;
  logic             adv;
  logic [4:0]       fifo_level;
  logic [PIX_W-1:0] lut_rd;
  logic [PIX_W-1:0] lut_knot0;

  function automatic logic [PIX_W-1:0] clip(input int v);
    return (v < 0) ? '0 : (v > PIX_MAX) ? PIX_W'(PIX_MAX) : PIX_W'(v);
  endfunction

  // Shared by gamma knots and table points; frac is in 1/div steps
  // Gamma divides by 255 so full white lands exactly on the top knot
  function automatic logic [PIX_W-1:0] interp(input logic [PIX_W-1:0] p0,
                                              input logic [PIX_W-1:0] p1,
                                              input logic [7:0] frac,
                                              input int div);
    return clip(int'(p0) + ((int'(p1) - int'(p0)) * int'(frac)) / div);
  endfunction

  function automatic logic [COEF_W-1:0] coef_clip(input int v);
    if (v > int'(COEF_MAX)) begin
      return COEF_MAX;
    end
    if (v < int'(COEF_MIN)) begin
      return COEF_MIN;
    end
    return COEF_W'(v);
  endfunction

  function automatic logic [PIX_W-1:0] enc(input logic [PIX_W-1:0] v, input depth_e dp);
    return v >> ((int'(DEPTH_12) - int'(dp)) * DEPTH_STEP);
  endfunction

  // Hue in half degrees, hexcone form; division kept combinational
  function automatic pix_t to_hsi(input pix_t p);
    int r;
    int g;
    int b;
    int mx;
    int mn;
    int dl;
    int h;
    int i;
    int s;
    r  = int'(p[0]);
    g  = int'(p[1]);
    b  = int'(p[2]);
    mx = (r > g) ? ((r > b) ? r : b) : ((g > b) ? g : b);
    mn = (r < g) ? ((r < b) ? r : b) : ((g < b) ? g : b);
    dl = mx - mn;
    i  = (r + g + b) / CH_N;
    s  = (i == 0) ? 0 : ((i - mn) * PIX_MAX) / i;
    if (dl == 0) begin
      h = 0;
    end else if (mx == r) begin
      h = HUE_SIXTH * (g - b) / dl;
    end else if (mx == g) begin
      h = 2 * HUE_SIXTH + HUE_SIXTH * (b - r) / dl;
    end else begin
      h = 4 * HUE_SIXTH + HUE_SIXTH * (r - g) / dl;
    end
    if (h < 0) begin
      h = h + HUE_FULL;
    end
    return {PIX_W'(i), PIX_W'(s), PIX_W'(h)};
  endfunction

  assign pin = {pix_blue, pix_green, pix_red};

  for (genvar g = 0; g < GAMMA_N; g++) begin : g_gam
    for (genvar k = 0; k <= GAMMA_KNOTS; k++) begin : g_knot
      localparam real V = PIX_MAX * ((k * 1.0 / GAMMA_KNOTS) ** GAMMA_EXP[g]);
      assign gam_rom[g][k] = PIX_W'(int'(V));
    end
  end

  for (genvar c = 0; c < CH_N; c++) begin : g_tone
    localparam int LC = COLOR_MODEL ? c : 0;
    logic [GAM_SEG_W-1:0] seg;
    logic [LUT_IDX_W-1:0] idx;
    assign seg = pin[c][PIX_W-1 -: GAM_SEG_W];
    assign idx = pin[c][PIX_W-1 -: LUT_IDX_W];
    always_comb begin
      unique case (q.tone)
        TONE_GAMMA: tone[c] = interp(gam_rom[q.gamma][seg],
                                     gam_rom[q.gamma][{1'b0, seg} + 5'h01],
                                     pin[c][PIX_W-GAM_SEG_W-1:0], INTERP_ONE - 1);
        TONE_LUT:   tone[c] = interp(lut_q[LC][idx], lut_q[LC][{1'b0, idx} + 9'h001],
                                     {pin[c][PIX_W-LUT_IDX_W-1:0], 4'h0}, INTERP_ONE);
        default:    tone[c] = pin[c];
      endcase
    end
    assign sh[c] = q.sharp_en
      ? clip(int'(q.s1[c]) + (int'(q.sharp_lvl) + 1)
             * (2 * int'(q.s1[c]) - int'(q.h1[c]) - int'(q.h2[c])) / SHARP_DIV)
      : q.s1[c];
    assign cv[c] = clip((int'($signed(mat[c*CH_N])) * int'(sh[0])
                       + int'($signed(mat[c*CH_N+1])) * int'(sh[1])
                       + int'($signed(mat[c*CH_N+2])) * int'(sh[2])) >>> FRAC_W);
  end

  assign mat = (q.cs == CS_XYZ)         ? MAT_XYZ :
               (q.rgbv == RGBV_WIDE)    ? MAT_WIDE :
               (q.rgbv == RGBV_CUSTOM)  ? q.coef : MAT_STD;

  assign hsi = to_hsi(sh);

  assign res = (q.cs == CS_HSI)
    ? {enc(hsi[2], q.depth), enc(hsi[1], q.depth),
       (q.depth == DEPTH_8) ? (hsi[0] >> HUE_8BIT_SHIFT) : hsi[0]}
    : {enc(cv[2], q.depth), enc(cv[1], q.depth), enc(cv[0], q.depth)};

  assign lut_rd    = lut_q[q.chan][q.index];
  assign lut_knot0 = lut_q[0][pix_red[PIX_W-1 -: LUT_IDX_W]];
  assign pix_ready = adv;
  assign reg_rdata = q.rdata;

  always_comb begin
    d       = q;
    d.rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        REG_TONE: begin
          d.tone  = tone_e'(reg_wdata[1:0]);
          d.gamma = (reg_wdata[F_GAMMA_LSB +: 4] > GAMMA_RST)
                    ? GAMMA_RST : reg_wdata[F_GAMMA_LSB +: 4];
        end
        REG_CHAN: if (COLOR_MODEL && reg_wdata[1:0] <= 2'(CH_N - 1)) begin
          d.chan = reg_wdata[1:0];
        end
        REG_INDEX: if (reg_wdata[8:0] <= INDEX_LAST) begin
          d.index = reg_wdata[8:0];
        end
        REG_CSPACE: if (COLOR_MODEL && reg_wdata[1:0] != 2'h3) begin
          d.cs   = cspace_e'(reg_wdata[1:0]);
          d.rgbv = (d.cs == CS_RGB) ? rgbv_e'(reg_wdata[F_RGBV_LSB +: 2]) : RGBV_OFF;
        end
        REG_COEF_SEL: if (reg_wdata[3:0] <= COEF_LAST) begin
          d.coef_sel = reg_wdata[3:0];
        end
        REG_COEF_VAL: d.coef[q.coef_sel] = coef_clip($signed(reg_wdata));
        REG_SHARP: begin
          d.sharp_en  = reg_wdata[0];
          d.sharp_lvl = reg_wdata[F_LEVEL_LSB +: 2];
        end
        REG_DEPTH: if (reg_wdata[1:0] != 2'h3) begin
          d.depth = depth_e'(reg_wdata[1:0]);
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_TONE:     d.rdata = 32'({q.gamma, 2'h0, q.tone});
        REG_CHAN:     d.rdata = 32'(q.chan);
        REG_INDEX:    d.rdata = 32'(q.index);
        REG_VALUE:    d.rdata = 32'(lut_rd);
        REG_CSPACE:   d.rdata = 32'({q.rgbv, 2'h0, q.cs});
        REG_COEF_SEL: d.rdata = 32'(q.coef_sel);
        REG_COEF_VAL: d.rdata = 32'($signed(q.coef[q.coef_sel]));
        REG_SHARP:    d.rdata = 32'({q.sharp_lvl, 3'h0, q.sharp_en});
        REG_DEPTH:    d.rdata = 32'(q.depth);
        REG_STATUS:   d.rdata = 32'({fifo_level, q.s2_v, q.s1_v});
        default:      d.rdata = '0;
      endcase
    end
    // Whole pipe stalls on a full FIFO so no pixel is dropped
    if (adv) begin
      d.s1_v = pix_valid;
      d.s1   = tone;
      d.s2_v = q.s1_v;
      d.s2   = res;
      if (q.s1_v) begin
        d.h1 = q.s1;
        d.h2 = q.h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // single entry write; reset to an identity curve
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < CH_N; c++) begin
        for (int i = 0; i < LUT_PTS; i++) begin
          lut_q[c][i] <= PIX_W'((i * LUT_STEP > PIX_MAX) ? PIX_MAX : i * LUT_STEP);
        end
      end
    end else if (reg_wr && reg_addr == REG_VALUE) begin
      lut_q[q.chan][q.index] <= reg_wdata[PIX_W-1:0];
    end
  end

  pixel_fifo #(
    .WIDTH (CH_N * PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (q.s2_v),
    .in_ready  (adv),
    .in_data   (q.s2),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  ({out_blue, out_green, out_red}),
    .level     (fifo_level)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence take_px;
    adv && pix_valid;
  endsequence

  sequence hsi_step(depth_e dp);
    adv && q.s1_v && q.cs == CS_HSI && q.depth == dp && !q.sharp_en;
  endsequence

  chk_gamma_black: assert property (
    take_px and (q.tone == TONE_GAMMA && pix_red == '0) |=> q.s1[0] == '0)
    else $error("gamma did not keep black at zero");

  chk_lut_write: assert property (
    (reg_wr && reg_addr == REG_VALUE) |=> lut_rd == $past(reg_wdata[PIX_W-1:0]))
    else $error("table write not stored at selected entry");

  chk_lut_knot: assert property (
    take_px and (q.tone == TONE_LUT && pix_red[LUT_IDX_W-5:0] == '0)
    |=> q.s1[0] == $past(lut_knot0))
    else $error("table output at a knot differs from stored point");

  chk_tone_bypass: assert property (
    take_px and (q.tone == TONE_OFF) |=> q.s1[0] == $past(pix_red))
    else $error("tone bypass altered pixel");

  chk_rgbv_forced: assert property (
    q.cs != CS_RGB |-> q.rgbv == RGBV_OFF)
    else $error("rgb variant not off outside rgb");

  chk_coef_range: assert property (
    $signed(q.coef[q.coef_sel]) <= COEF_MAX && $signed(q.coef[q.coef_sel]) >= COEF_MIN)
    else $error("coefficient outside plus minus two");

  chk_sharp_bypass: assert property (
    (adv && q.s1_v && !q.sharp_en && q.cs == CS_RGB && q.rgbv == RGBV_OFF
     && q.depth == DEPTH_12) |=> q.s2 == $past(q.s1))
    else $error("disabled enhancer altered pixel");

  chk_hue_8bit: assert property (
    hsi_step(DEPTH_8) |=> q.s2[0] < PIX_W'(HUE_8BIT_MAX))
    else $error("8-bit hue code beyond 360 degrees");

  chk_sat_full: assert property (
    hsi_step(DEPTH_12) and (q.s1[2] == '0 && q.s1[0] >= PIX_W'(CH_N))
    |=> q.s2[1] == PIX_W'(PIX_MAX))
    else $error("full saturation not all ones");
endmodule // pixel_tone_color_pipeline

// ==== pixel_stream_partner.sv ====
`timescale 1ns/1ps
module pixel_stream_partner
  import pixel_tone_pkg::*;
(
  input  logic             clk,
  input  logic             stall,
  output logic             pix_valid,
  input  logic             pix_ready,
  output logic [PIX_W-1:0] pix_red,
  output logic [PIX_W-1:0] pix_green,
  output logic [PIX_W-1:0] pix_blue,
  input  logic             out_valid,
  output logic             out_ready,
  input  logic [PIX_W-1:0] out_red,
  input  logic [PIX_W-1:0] out_green,
  input  logic [PIX_W-1:0] out_blue
);
  logic [3*PIX_W-1:0] got[$];

  initial begin
    pix_valid = 1'b0;
    {pix_red, pix_green, pix_blue} = '0;
    out_ready = 1'b0;
  end

  // Valid and data held until the edge that finds ready high
  task automatic send(input logic [3*PIX_W-1:0] p);
    {pix_red, pix_green, pix_blue} <= p;
    pix_valid <= 1'b1;
    do @(posedge clk); while (pix_ready !== 1'b1);
  endtask

  // Released lines show the inverse, so stale data never looks valid
  task automatic idle();
    pix_valid <= 1'b0;
    {pix_red, pix_green, pix_blue} <= ~{pix_red, pix_green, pix_blue};
  endtask

  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got.push_back({out_red, out_green, out_blue});
    end
    out_ready <= !stall;
  end
endmodule // pixel_stream_partner

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import pixel_tone_pkg::*;
;
  logic             clk;
  logic             rst;
  logic             stall;
  logic [7:0]       reg_addr;
  logic [31:0]      reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [31:0]      reg_rdata;
  logic [31:0]      rv;
  logic             pix_valid;
  logic             pix_ready;
  logic             out_valid;
  logic             out_ready;
  logic [PIX_W-1:0] pix_red, pix_green, pix_blue;
  logic [PIX_W-1:0] out_red, out_green, out_blue;
  logic [35:0]      q;
  int               failures = 0;
  int               tests_run = 0;
  int               cyc = 0;

  pixel_tone_color_pipeline #(.COLOR_MODEL(1'b1)) dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_red(pix_red),
    .pix_green(pix_green), .pix_blue(pix_blue), .out_valid(out_valid),
    .out_ready(out_ready), .out_red(out_red), .out_green(out_green),
    .out_blue(out_blue));

  pixel_stream_partner p_u (
    .clk(clk), .stall(stall), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
    .out_valid(out_valid), .out_ready(out_ready), .out_red(out_red),
    .out_green(out_green), .out_blue(out_blue));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  task automatic collect(input int n);
    int k = 0;
    while (p_u.got.size() < n && k < 60) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic px(input logic [35:0] p, output logic [35:0] o);
    p_u.send(p);
    p_u.idle();
    collect(1);
    o = (p_u.got.size() > 0) ? p_u.got.pop_front() : 'x;
  endtask

  // Two black pixels then a mid step, so the edge term is known
  task automatic edge3(output logic [35:0] o);
    p_u.send('0);
    p_u.send('0);
    p_u.send({3{12'h320}});
    p_u.idle();
    collect(3);
    o = 'x;
    while (p_u.got.size() > 0) o = p_u.got.pop_front();
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    stall = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(REG_TONE, rv); chk(rv, 32'h80);
    rd(REG_CSPACE, rv); chk(rv, 32'h0);
    rd(REG_DEPTH, rv); chk(rv, 32'h2);
    rd(REG_COEF_VAL, rv); chk(rv, 32'h400);
    rd(REG_SHARP, rv); chk(rv, 32'h0);
    rd(8'h40, rv); chk(rv, 32'h0);
    px({12'h064, 12'h7D0, 12'hFFF}, q); chk(q, {12'h064, 12'h7D0, 12'hFFF});
    wr(REG_TONE, 32'h83);
    px({12'h001, 12'hABC, 12'h000}, q); chk(q, {12'h001, 12'hABC, 12'h000});
    wr(REG_TONE, 32'h82);
    wr(REG_CHAN, 32'h0);
    wr(REG_INDEX, 32'h1);
    wr(REG_VALUE, 32'h64);
    wr(REG_INDEX, 32'h2);
    wr(REG_VALUE, 32'h12C);
    wr(REG_CHAN, 32'h2);
    wr(REG_INDEX, 32'h100);
    wr(REG_VALUE, 32'h0);
    wr(REG_INDEX, 32'h101);
    rd(REG_INDEX, rv); chk(rv, 32'h100);
    rd(REG_VALUE, rv); chk(rv, 32'h0);
    wr(REG_CHAN, 32'h1);
    rd(REG_VALUE, rv); chk(rv, 32'hFFF);
    wr(REG_INDEX, 32'h5);
    rd(REG_VALUE, rv); chk(rv, 32'h50);
    px({12'h010, 12'h000, 12'h000}, q); chk(q, {12'h064, 12'h000, 12'h000});
    px({12'h018, 12'h018, 12'hFFF}, q); chk(q, {12'h0C8, 12'h018, 12'h0FF});
    for (int g = 0; g < 9; g++) begin
      wr(REG_TONE, 32'((g << 4) | 1));
      rd(REG_TONE, rv); chk(rv, 32'((g << 4) | 1));
      px({12'h000, 12'hFFF, 12'h000}, q); chk(q, {12'h000, 12'hFFF, 12'h000});
    end
    px({3{12'h3E8}}, q); chk(q, {3{12'h3E8}});
    wr(REG_TONE, 32'hC1);
    rd(REG_TONE, rv); chk(rv, 32'h81);
    wr(REG_TONE, 32'h0);
    wr(REG_CSPACE, 32'h31);
    rd(REG_CSPACE, rv); chk(rv, 32'h01);
    wr(REG_CSPACE, 32'h32);
    rd(REG_CSPACE, rv); chk(rv, 32'h02);
    wr(REG_CSPACE, 32'h1);
    wr(REG_DEPTH, 32'h0);
    px({12'h000, 12'hFFF, 12'h000}, q); chk(q[35:12], {12'h03C, 12'h0FF});
    wr(REG_DEPTH, 32'h2);
    px({12'h000, 12'h000, 12'hFFF}, q); chk(q[35:12], {12'h1E0, 12'hFFF});
    px({12'hFFF, 12'h000, 12'h000}, q); chk(q, {12'h000, 12'hFFF, 12'h555});
    wr(REG_DEPTH, 32'h1);
    px({3{12'hFFF}}, q); chk(q[23:0], {12'h000, 12'h3FF});
    wr(REG_DEPTH, 32'h2);
    wr(REG_CSPACE, 32'h30);
    rd(REG_CSPACE, rv); chk(rv, 32'h30);
    wr(REG_COEF_SEL, 32'h0);
    wr(REG_COEF_VAL, 32'h800);
    wr(REG_COEF_SEL, 32'h1);
    wr(REG_COEF_VAL, 32'hFFFFFC00);
    wr(REG_COEF_SEL, 32'h9);
    rd(REG_COEF_SEL, rv); chk(rv, 32'h1);
    px({12'h3E8, 12'h12C, 12'h000}, q); chk(q, {12'h6A4, 12'h12C, 12'h000});
    wr(REG_COEF_VAL, 32'h1000);
    rd(REG_COEF_VAL, rv); chk(rv, 32'h800);
    wr(REG_COEF_VAL, 32'hFFFFE000);
    rd(REG_COEF_VAL, rv); chk(rv, 32'hFFFFF800);
    wr(REG_CSPACE, 32'h10);
    px({12'h3E8, 12'h12C, 12'h000}, q); chk(q, {12'h3E8, 12'h12C, 12'h000});
    wr(REG_CSPACE, 32'h0);
    for (int l = 0; l < 4; l++) begin
      wr(REG_SHARP, 32'((l << 4) | 1));
      edge3(q); chk(q[35:24], 12'(800 + 200 * (l + 1)));
    end
    wr(REG_SHARP, 32'h30);
    edge3(q); chk(q[35:24], 12'h320);
    stall <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 18; i++) p_u.send({12'(i * 100 + 1), 12'(i), 12'h000});
    p_u.idle();
    repeat (3) @(posedge clk);
    chk(pix_ready, 1'b0);
    rd(REG_STATUS, rv); chk(rv, 32'h43);
    stall <= 1'b0;
    collect(18);
    chk(p_u.got.size(), 18);
    for (int i = 0; i < 18; i++) begin
      q = (p_u.got.size() > 0) ? p_u.got.pop_front() : 'x;
      chk(q, {12'(i * 100 + 1), 12'(i), 12'h000});
    end
    rd(REG_STATUS, rv); chk(rv, 32'h0);
    give_verdict();
  end
endmodule // tb_top
